/* File: hbd_pkg.sv */
// package: request codes, response codes, queue sizes and shared structs for host decode
package hbd_pkg;

  // ---------------------------------------------------------------
  // queue sizing
  // ---------------------------------------------------------------
  localparam int unsigned IOQ_DEPTH = 4;
  localparam logic [2:0] IOQ_DEPTH_CNT = 3'h4;
  localparam logic [2:0] CNT_RST = 3'h0;
  localparam logic [1:0] PTR_RST = 2'h0;

  // ---------------------------------------------------------------
  // first request codes
  // ---------------------------------------------------------------
  localparam logic [4:0] RQA_DEFER_REPLY = 5'h00;
  localparam logic [4:0] RQA_INTA_SPEC = 5'h08;
  localparam logic [4:0] RQA_BTM = 5'h09;
  localparam logic [4:0] RQA_IO_RD = 5'h10;
  localparam logic [4:0] RQA_IO_WR = 5'h11;
  localparam logic [2:0] RQA_MEM_RDINV = 3'h2;
  localparam logic [2:0] RQA_MEM_CODE = 3'h4;
  localparam logic [2:0] RQA_MEM_WB = 3'h5;
  localparam logic [2:0] RQA_MEM_DATA = 3'h6;
  localparam logic [2:0] RQA_MEM_WR = 3'h7;
  localparam logic [1:0] ADDR_SIZE_32BIT = 2'h0;

  // ---------------------------------------------------------------
  // second request codes and fields
  // ---------------------------------------------------------------
  localparam logic [4:0] RQB_INTA = 5'h00;
  localparam logic [4:0] RQB_BTM = 5'h00;
  localparam logic [2:0] RQB_SPEC_LOW = 3'h1;
  localparam logic [1:0] DATA_SIZE_64BIT = 2'h0;
  localparam logic [1:0] LEN_8B = 2'h0;
  localparam logic [1:0] LEN_16B = 2'h1;
  localparam logic [1:0] LEN_32B = 2'h2;
  localparam logic [1:0] LEN_RSVD = 2'h3;
  localparam logic [7:0] LANES_NONE = 8'h00;

  // ---------------------------------------------------------------
  // response status
  // ---------------------------------------------------------------
  localparam logic [2:0] RS_IDLE = 3'h0;
  localparam logic [2:0] RS_RETRY = 3'h1;
  localparam logic [2:0] RS_DEFER = 3'h2;
  localparam logic [2:0] RS_RSVD = 3'h3;
  localparam logic [2:0] RS_HARDFAIL = 3'h4;
  localparam logic [2:0] RS_NODATA = 3'h5;
  localparam logic [2:0] RS_IWB = 3'h6;
  localparam logic [2:0] RS_NORMAL = 3'h7;

  typedef enum logic [2:0] {
    HBD_DST_NONE = 3'h0,
    HBD_DST_DRAM = 3'h1,
    HBD_DST_HUB = 3'h2,
    HBD_DST_CFG = 3'h3,
    HBD_DST_SPEC = 3'h4,
    HBD_DST_BAD = 3'h5
  } hbd_dst_t;

  typedef enum logic [3:0] {
    HBD_TT_NONE = 4'h0,
    HBD_TT_DEFER_REPLY = 4'h1,
    HBD_TT_INTA = 4'h2,
    HBD_TT_SPECIAL = 4'h3,
    HBD_TT_BTM = 4'h4,
    HBD_TT_IO_RD = 4'h5,
    HBD_TT_IO_WR = 4'h6,
    HBD_TT_MEM_RD = 4'h7,
    HBD_TT_MEM_WB = 4'h8,
    HBD_TT_MEM_WR = 4'h9,
    HBD_TT_RSVD = 4'hA
  } hbd_ttype_t;

  // request as seen on the host bus in the two request phases
  typedef struct packed {
    logic valid;
    logic [4:0] request_code_first;
    logic [4:0] request_code_second;
    logic [7:0] byte_lane_enables;
    logic cfg_hit;
    logic dram_hit;
    logic locked;
  } hbd_req_t;

  // answer from the back end for the oldest entry
  typedef struct packed {
    logic valid;
    logic busy;
    logic snoop_hitm;
    logic defer_ok;
  } hbd_cpl_t;

  typedef struct packed {
    hbd_ttype_t ttype;
    hbd_dst_t dst;
    logic is_read;
    logic zero_len;
    logic locked;
  } hbd_ent_t;

  typedef enum logic [1:0] {
    HBD_ST_IDLE = 2'b00,
    HBD_ST_WAIT = 2'b01,
    HBD_ST_RESP = 2'b11
  } hbd_state_t;

endpackage : hbd_pkg

/* File: hbd_host_decode.sv */
// module: host bus request decode, in-order queue and response status selection
// What this block does
// - keep at most four outstanding requests; refuse new ones while four are pending
// - responses leave strictly in the order requests arrived
// - first code 00000 is our own deferred reply for an earlier deferred transaction
// - codes 01000/00000 decode as interrupt acknowledge, sent to the hub
// - codes 01000/xx001 decode as special transaction, sent to special-cycle logic
// - codes 01001/00000 are branch trace: terminated, no data captured
// - I/O read 10000 and I/O write 10001 go to the hub
// - I/O hitting own configuration space is handled internally, not forwarded
// - memory read codes 00010, 00100, 00110 go to DRAM or hub by address
// - writeback 00101 is never retried and always goes to DRAM
// - retryable write 00111 goes to DRAM or hub by address
// - memory address size field must be 00, 32-bit addressing
// - data size field must be 00, 64-bit data bus
// - length 00 up to 8 bytes by enables, 01 is 16, 10 is 32, 11 reserved
// - retry 001 only when target is busy, only for hub traffic or locked DRAM reads
// - deferred 010 only for hub reads, I/O writes and internal reads or I/O writes
// - writes, zero-length reads and data-done transactions get no data 101
// - implicit writeback 110 when the snoop hits a modified line
// - reads returning data get normal data 111; 000 is idle
// - special transaction type comes from the second address phase only
module hbd_host_decode
  import hbd_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire hbd_req_t req_i,
  input wire hbd_cpl_t cpl_i,
  output logic req_ready_o,
  output hbd_ent_t disp_o,
  output logic disp_valid_o,
  output logic [2:0] response_status_o,
  output logic resp_valid_o,
  output logic defer_reply_o,
  output logic [2:0] pending_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    hbd_ent_t [IOQ_DEPTH-1:0] q;
    logic [1:0] wr_ptr;
    logic [1:0] rd_ptr;
    logic [2:0] cnt;
    hbd_state_t st;
    hbd_ent_t disp;
    logic disp_valid;
    logic [2:0] rs;
    logic rs_valid;
    logic defer_reply;
    logic ready;
  } hbd_regs_t;

  hbd_regs_t s_r;
  hbd_regs_t s_nxt;
  hbd_ent_t dec;
  hbd_ent_t head;
  logic [1:0] len;
  logic take;
  logic pop;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  always_comb begin
    dec = '{ttype: HBD_TT_RSVD, dst: HBD_DST_BAD, is_read: 1'b0, zero_len: 1'b0,
            locked: req_i.locked};
    len = req_i.request_code_second[1:0];
    if (req_i.request_code_first == RQA_DEFER_REPLY) begin
      dec.ttype = HBD_TT_DEFER_REPLY;
      dec.dst = HBD_DST_NONE;
    end else if (req_i.request_code_first == RQA_INTA_SPEC) begin
      if (req_i.request_code_second == RQB_INTA) begin
        dec.ttype = HBD_TT_INTA;
        dec.dst = HBD_DST_HUB;
        dec.is_read = 1'b1;
      end else if (req_i.request_code_second[2:0] == RQB_SPEC_LOW) begin
        // first address phase is don't-care; type rides in the second phase
        dec.ttype = HBD_TT_SPECIAL;
        dec.dst = HBD_DST_SPEC;
      end
    end else if (req_i.request_code_first == RQA_BTM
                 && req_i.request_code_second == RQB_BTM) begin
      dec.ttype = HBD_TT_BTM;
      dec.dst = HBD_DST_NONE;
    end else if (req_i.request_code_first == RQA_IO_RD
                 || req_i.request_code_first == RQA_IO_WR) begin
      dec.is_read = (req_i.request_code_first == RQA_IO_RD);
      dec.ttype = dec.is_read ? HBD_TT_IO_RD : HBD_TT_IO_WR;
      dec.dst = req_i.cfg_hit ? HBD_DST_CFG : HBD_DST_HUB;
    end else if (req_i.request_code_first[4:3] == ADDR_SIZE_32BIT
                 && req_i.request_code_second[4:3] == DATA_SIZE_64BIT
                 && len != LEN_RSVD) begin
      // anything else (odd size fields, reserved length) stays reserved
      case (req_i.request_code_first[2:0])
        RQA_MEM_RDINV, RQA_MEM_CODE, RQA_MEM_DATA: begin
          dec.ttype = HBD_TT_MEM_RD;
          dec.is_read = 1'b1;
          dec.dst = req_i.dram_hit ? HBD_DST_DRAM : HBD_DST_HUB;
        end
        RQA_MEM_WB: begin
          dec.ttype = HBD_TT_MEM_WB;
          dec.dst = HBD_DST_DRAM;
        end
        RQA_MEM_WR: begin
          dec.ttype = HBD_TT_MEM_WR;
          dec.dst = req_i.dram_hit ? HBD_DST_DRAM : HBD_DST_HUB;
        end
        default: begin
          dec.ttype = HBD_TT_RSVD;
        end
      endcase
      // short read with no lanes enabled carries no data
      dec.zero_len = dec.is_read && len == LEN_8B
                     && req_i.byte_lane_enables == LANES_NONE;
    end
  end

  // ---------------------------------------------------------------
  // queue and response selection
  // ---------------------------------------------------------------
  assign head = s_r.q[s_r.rd_ptr];
  assign take = req_i.valid && s_r.ready;

  function automatic logic [2:0] pick_rs(input hbd_ent_t e, input hbd_cpl_t c);
    logic retry_ok;
    logic defer_ok;
    retry_ok = (e.dst == HBD_DST_HUB && e.ttype != HBD_TT_MEM_WB)
               || (e.dst == HBD_DST_DRAM && e.is_read && e.locked);
    defer_ok = (e.dst == HBD_DST_HUB && (e.is_read || e.ttype == HBD_TT_IO_WR))
               || (e.dst == HBD_DST_CFG && (e.is_read || e.ttype == HBD_TT_IO_WR));
    if (c.busy && retry_ok) begin
      pick_rs = RS_RETRY;
    end else if (c.defer_ok && defer_ok) begin
      pick_rs = RS_DEFER;
    end else if (c.snoop_hitm) begin
      pick_rs = RS_IWB;
    end else if (e.is_read && !e.zero_len) begin
      pick_rs = RS_NORMAL;
    end else begin
      pick_rs = RS_NODATA;
    end
  endfunction : pick_rs

  always_comb begin
    s_nxt = s_r;
    s_nxt.disp_valid = 1'b0;
    s_nxt.rs = RS_IDLE;
    s_nxt.rs_valid = 1'b0;
    s_nxt.defer_reply = 1'b0;
    pop = 1'b0;
    case (s_r.st)
      HBD_ST_IDLE: begin
        if (s_r.cnt != CNT_RST) begin
          s_nxt.st = HBD_ST_WAIT;
        end
      end
      HBD_ST_WAIT: begin
        // only the oldest entry may complete
        if (cpl_i.valid) begin
          s_nxt.rs = pick_rs(head, cpl_i);
          s_nxt.rs_valid = 1'b1;
          s_nxt.st = HBD_ST_RESP;
          pop = 1'b1;
        end
      end
      HBD_ST_RESP: begin
        s_nxt.st = HBD_ST_IDLE;
      end
      default: begin
        s_nxt.st = HBD_ST_IDLE;
      end
    endcase
    if (take) begin
      s_nxt.q[s_r.wr_ptr] = dec;
      s_nxt.wr_ptr = s_r.wr_ptr + 2'h1;
      s_nxt.disp = dec;
      s_nxt.disp_valid = 1'b1;
      s_nxt.defer_reply = (dec.ttype == HBD_TT_DEFER_REPLY);
    end
    if (pop) begin
      s_nxt.rd_ptr = s_r.rd_ptr + 2'h1;
    end
    s_nxt.cnt = s_r.cnt + {2'h0, take} - {2'h0, pop};
    s_nxt.ready = (s_nxt.cnt != IOQ_DEPTH_CNT);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.st <= HBD_ST_IDLE;
      s_r.cnt <= CNT_RST;
      s_r.wr_ptr <= PTR_RST;
      s_r.rd_ptr <= PTR_RST;
      s_r.ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign req_ready_o = s_r.ready;
  assign disp_o = s_r.disp;
  assign disp_valid_o = s_r.disp_valid;
  assign response_status_o = s_r.rs;
  assign resp_valid_o = s_r.rs_valid;
  assign defer_reply_o = s_r.defer_reply;
  assign pending_o = s_r.cnt;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence full_seen;
    s_r.cnt == IOQ_DEPTH_CNT;
  endsequence

  queue_limit_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    full_seen |-> !req_ready_o ##1 ($stable(s_r.wr_ptr) && s_r.cnt <= IOQ_DEPTH_CNT))
    else $error("queue accepted past four");
  order_pop_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    resp_valid_o |-> s_r.rd_ptr == $past(s_r.rd_ptr) + 2'h1)
    else $error("response out of order");
  no_bad_rs_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    response_status_o != RS_HARDFAIL && response_status_o != RS_RSVD)
    else $error("forbidden response status");
  idle_rs_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !resp_valid_o |-> response_status_o == RS_IDLE)
    else $error("status not idle");
  wb_dram_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    disp_valid_o && disp_o.ttype == HBD_TT_MEM_WB |-> disp_o.dst == HBD_DST_DRAM)
    else $error("writeback not sent to dram");
  io_cfg_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    take && req_i.request_code_first == RQA_IO_WR && req_i.cfg_hit
    |=> disp_o.dst == HBD_DST_CFG)
    else $error("config io forwarded");
  inta_hub_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    take && req_i.request_code_first == RQA_INTA_SPEC && req_i.request_code_second == RQB_INTA
    |=> disp_o.ttype == HBD_TT_INTA && disp_o.dst == HBD_DST_HUB)
    else $error("interrupt ack misrouted");
  wb_retry_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cpl_i.valid && s_r.st == HBD_ST_WAIT && head.ttype == HBD_TT_MEM_WB
    |=> response_status_o != RS_RETRY)
    else $error("writeback retried");

  // completion with no busy, deferral or snoop hit: status falls to the data kind
  sequence plain_cpl;
    pop && !cpl_i.busy && !cpl_i.defer_ok && !cpl_i.snoop_hitm;
  endsequence

  // memory entry one cycle after its request was taken, so $past sees the request codes
  sequence mem_disp;
    disp_valid_o && (disp_o.ttype == HBD_TT_MEM_RD || disp_o.ttype == HBD_TT_MEM_WB
                     || disp_o.ttype == HBD_TT_MEM_WR);
  endsequence

  count_up_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    take && !pop |=> pending_o == $past(pending_o) + 3'h1)
    else $error("entry count did not rise");
  count_down_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pop && !take |=> pending_o == $past(pending_o) - 3'h1)
    else $error("entry count did not fall");
  accept_pulse_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    take |=> disp_valid_o)
    else $error("accepted request not dispatched");
  refuse_full_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !req_ready_o |=> !disp_valid_o)
    else $error("request taken while full");
  reply_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    take && req_i.request_code_first == RQA_DEFER_REPLY
    |=> defer_reply_o && disp_o.ttype == HBD_TT_DEFER_REPLY)
    else $error("deferred reply not flagged");
  reply_only_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    defer_reply_o |-> disp_valid_o && disp_o.ttype == HBD_TT_DEFER_REPLY)
    else $error("stray deferred reply flag");
  spec_route_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    take && req_i.request_code_first == RQA_INTA_SPEC
    && req_i.request_code_second[2:0] == RQB_SPEC_LOW
    |=> disp_o.ttype == HBD_TT_SPECIAL && disp_o.dst == HBD_DST_SPEC)
    else $error("special transaction misrouted");
  btm_drop_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    take && req_i.request_code_first == RQA_BTM && req_i.request_code_second == RQB_BTM
    |=> disp_o.dst == HBD_DST_NONE && !disp_o.is_read)
    else $error("branch trace data captured");
  io_hub_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    take && (req_i.request_code_first == RQA_IO_RD || req_i.request_code_first == RQA_IO_WR)
    && !req_i.cfg_hit |=> disp_o.dst == HBD_DST_HUB)
    else $error("io not sent to hub");
  mem_size_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    mem_disp |-> $past(req_i.request_code_first[4:3]) == ADDR_SIZE_32BIT
    && $past(req_i.request_code_second[4:3]) == DATA_SIZE_64BIT && $past(len) != LEN_RSVD)
    else $error("unsupported size decoded as memory");
  mem_route_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    mem_disp ##0 disp_o.ttype != HBD_TT_MEM_WB
    |-> disp_o.dst == ($past(req_i.dram_hit) ? HBD_DST_DRAM : HBD_DST_HUB))
    else $error("memory request misrouted");
  retry_scope_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    resp_valid_o && response_status_o == RS_RETRY
    |-> $past(cpl_i.busy && (head.dst == HBD_DST_HUB
        || (head.dst == HBD_DST_DRAM && head.is_read && head.locked))))
    else $error("retry outside its scope");
  defer_scope_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    resp_valid_o && response_status_o == RS_DEFER
    |-> $past((head.dst == HBD_DST_HUB || head.dst == HBD_DST_CFG)
        && (head.is_read || head.ttype == HBD_TT_IO_WR)))
    else $error("deferral outside its scope");
  snoop_iwb_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pop && cpl_i.snoop_hitm && !cpl_i.busy && !cpl_i.defer_ok
    |=> response_status_o == RS_IWB)
    else $error("snoop hit without writeback status");
  normal_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    plain_cpl ##0 (head.is_read && !head.zero_len) |=> response_status_o == RS_NORMAL)
    else $error("read without normal data");
  no_data_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    plain_cpl ##0 (!head.is_read || head.zero_len) |=> response_status_o == RS_NODATA)
    else $error("write or empty read not no-data");
  resp_pulse_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pop |=> resp_valid_o ##1 !resp_valid_o)
    else $error("response pulse malformed");

endmodule : hbd_host_decode

/* File: hbd_cpu_model.sv */
// partner model: host processor issuing two-phase bus requests
module hbd_cpu_model
  import hbd_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic req_ready_i,
  output hbd_req_t req_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    req_o = '0;
  end

  // ---------------------------------------------------------------
  // request phase
  // ---------------------------------------------------------------
  // both codes travel together and stay put up to the taking edge
  task automatic issue(input logic [4:0] a, input logic [4:0] b, input logic [7:0] be,
                       input logic [2:0] attr);
    @(posedge core_clk_i);
    req_o <= '{1'b1, a, b, be, attr[2], attr[1], attr[0]};
    @(negedge core_clk_i);
    for (int i = 0; i < 60 && req_ready_i !== 1'b1; i++) begin
      @(negedge core_clk_i);
    end
    @(posedge core_clk_i);
    // released lines show the inverse, so a stale copy cannot pass as a request
    req_o <= hbd_req_t'(~req_o);
  endtask : issue

  // presses a request for n cycles without waiting for room, used against a full queue
  task automatic hold_try(input int n);
    @(posedge core_clk_i);
    req_o <= '{1'b1, 5'h06, 5'h02, 8'hFF, 1'b0, 1'b1, 1'b0};
    repeat (n) @(posedge core_clk_i);
    req_o <= hbd_req_t'(~req_o);
  endtask : hold_try
endmodule : hbd_cpu_model

/* File: testbench.sv */
// testbench: decode, queue depth, ordering and response status of the host decode block
module testbench
  import hbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end

  logic core_clk_i;
  logic rst_i;
  hbd_req_t req;
  hbd_cpl_t cpl;
  logic req_ready_o;
  hbd_ent_t disp_o;
  logic disp_valid_o;
  logic [2:0] response_status_o;
  logic resp_valid_o;
  logic defer_reply_o;
  logic [2:0] pending_o;
  int num_errors = 0;
  int n_tests = 0;

  hbd_host_decode dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req), .cpl_i(cpl),
    .req_ready_o(req_ready_o), .disp_o(disp_o), .disp_valid_o(disp_valid_o),
    .response_status_o(response_status_o), .resp_valid_o(resp_valid_o),
    .defer_reply_o(defer_reply_o), .pending_o(pending_o));

  hbd_cpu_model cpu (.core_clk_i(core_clk_i), .req_ready_i(req_ready_o), .req_o(req));

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // ---------------------------------------------------------------
  // shared steps
  // ---------------------------------------------------------------
  // completion held until the oldest entry answers; bounded so a hang still ends
  task automatic complete(input logic [2:0] fl, input logic [2:0] rs);
    @(posedge core_clk_i);
    cpl <= '{1'b1, fl[2], fl[1], fl[0]};
    @(negedge core_clk_i);
    for (int i = 0; i < 20 && resp_valid_o !== 1'b1; i++) begin
      @(negedge core_clk_i);
    end
    `CHK("status", rs, response_status_o)
    `CHK("resp", 1'b1, resp_valid_o)
    @(posedge core_clk_i);
    cpl <= '0;
    @(negedge core_clk_i);
    `CHK("idle", RS_IDLE, response_status_o)
    `CHK("resp_end", 1'b0, resp_valid_o)
  endtask : complete

  // attr is cfg, dram, locked; fl is busy, snoop hit, defer wanted
  task automatic chk(input logic [4:0] a, input logic [4:0] b, input logic [7:0] be,
      input logic [2:0] attr, input logic [2:0] fl, input hbd_ttype_t tt,
      input hbd_dst_t dst, input logic [2:0] rs);
    cpu.issue(a, b, be, attr);
    @(negedge core_clk_i);
    `CHK("accept", 1'b1, disp_valid_o)
    `CHK("ttype", tt, disp_o.ttype)
    `CHK("dst", dst, disp_o.dst)
    `CHK("read", (tt inside {HBD_TT_INTA, HBD_TT_IO_RD, HBD_TT_MEM_RD}), disp_o.is_read)
    `CHK("zero", (tt == HBD_TT_MEM_RD && be == 8'h00 && b[1:0] == 2'h0), disp_o.zero_len)
    `CHK("locked", attr[0], disp_o.locked)
    `CHK("reply", a == 5'h00, defer_reply_o)
    complete(fl, rs);
    `CHK("pending", 3'h0, pending_o)
  endtask : chk

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_decode();
    chk(5'h00, 5'h00, 8'hFF, 3'b000, 3'b000, HBD_TT_DEFER_REPLY, HBD_DST_NONE, RS_NODATA);
    chk(5'h08, 5'h00, 8'hFF, 3'b000, 3'b000, HBD_TT_INTA, HBD_DST_HUB, RS_NORMAL);
    chk(5'h08, 5'h01, 8'h00, 3'b000, 3'b000, HBD_TT_SPECIAL, HBD_DST_SPEC, RS_NODATA);
    chk(5'h08, 5'h09, 8'h03, 3'b000, 3'b000, HBD_TT_SPECIAL, HBD_DST_SPEC, RS_NODATA);
    chk(5'h08, 5'h02, 8'hFF, 3'b000, 3'b000, HBD_TT_RSVD, HBD_DST_BAD, RS_NODATA);
    chk(5'h09, 5'h00, 8'hFF, 3'b000, 3'b000, HBD_TT_BTM, HBD_DST_NONE, RS_NODATA);
    chk(5'h10, 5'h00, 8'h0F, 3'b000, 3'b000, HBD_TT_IO_RD, HBD_DST_HUB, RS_NORMAL);
    chk(5'h10, 5'h00, 8'h0F, 3'b100, 3'b000, HBD_TT_IO_RD, HBD_DST_CFG, RS_NORMAL);
    chk(5'h11, 5'h00, 8'h0F, 3'b100, 3'b000, HBD_TT_IO_WR, HBD_DST_CFG, RS_NODATA);
    chk(5'h02, 5'h02, 8'hFF, 3'b010, 3'b000, HBD_TT_MEM_RD, HBD_DST_DRAM, RS_NORMAL);
    chk(5'h03, 5'h02, 8'hFF, 3'b010, 3'b000, HBD_TT_RSVD, HBD_DST_BAD, RS_NODATA);
    chk(5'h05, 5'h02, 8'hFF, 3'b000, 3'b100, HBD_TT_MEM_WB, HBD_DST_DRAM, RS_NODATA);
    chk(5'h07, 5'h01, 8'hFF, 3'b010, 3'b000, HBD_TT_MEM_WR, HBD_DST_DRAM, RS_NODATA);
    chk(5'h16, 5'h02, 8'hFF, 3'b010, 3'b000, HBD_TT_RSVD, HBD_DST_BAD, RS_NODATA);
    chk(5'h06, 5'h0A, 8'hFF, 3'b010, 3'b000, HBD_TT_RSVD, HBD_DST_BAD, RS_NODATA);
    chk(5'h06, 5'h03, 8'hFF, 3'b010, 3'b000, HBD_TT_RSVD, HBD_DST_BAD, RS_NODATA);
    $display("t_decode done");
  endtask : t_decode

  task automatic t_status();
    chk(5'h11, 5'h00, 8'h0F, 3'b000, 3'b100, HBD_TT_IO_WR, HBD_DST_HUB, RS_RETRY);
    chk(5'h07, 5'h02, 8'hFF, 3'b000, 3'b100, HBD_TT_MEM_WR, HBD_DST_HUB, RS_RETRY);
    chk(5'h06, 5'h02, 8'hFF, 3'b010, 3'b100, HBD_TT_MEM_RD, HBD_DST_DRAM, RS_NORMAL);
    chk(5'h06, 5'h02, 8'hFF, 3'b011, 3'b100, HBD_TT_MEM_RD, HBD_DST_DRAM, RS_RETRY);
    chk(5'h04, 5'h02, 8'hFF, 3'b000, 3'b001, HBD_TT_MEM_RD, HBD_DST_HUB, RS_DEFER);
    chk(5'h08, 5'h00, 8'hFF, 3'b000, 3'b001, HBD_TT_INTA, HBD_DST_HUB, RS_DEFER);
    chk(5'h06, 5'h02, 8'hFF, 3'b010, 3'b001, HBD_TT_MEM_RD, HBD_DST_DRAM, RS_NORMAL);
    chk(5'h06, 5'h02, 8'hFF, 3'b010, 3'b010, HBD_TT_MEM_RD, HBD_DST_DRAM, RS_IWB);
    chk(5'h06, 5'h00, 8'h00, 3'b010, 3'b000, HBD_TT_MEM_RD, HBD_DST_DRAM, RS_NODATA);
    $display("t_status done");
  endtask : t_status

  // fills the queue, presses a fifth request, then drains; mixed answers expose reordering
  task automatic t_queue();
    cpu.issue(5'h11, 5'h00, 8'h0F, 3'b000);
    cpu.issue(5'h06, 5'h02, 8'hFF, 3'b010);
    cpu.issue(5'h06, 5'h00, 8'h00, 3'b010);
    cpu.issue(5'h04, 5'h02, 8'hFF, 3'b000);
    @(negedge core_clk_i);
    `CHK("full", 3'h4, pending_o)
    `CHK("ready", 1'b0, req_ready_o)
    cpu.hold_try(3);
    @(negedge core_clk_i);
    `CHK("refused", 3'h4, pending_o)
    complete(3'b100, RS_RETRY);
    complete(3'b100, RS_NORMAL);
    complete(3'b100, RS_NODATA);
    complete(3'b100, RS_RETRY);
    `CHK("drained", 3'h0, pending_o)
    $display("t_queue done");
  endtask : t_queue

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  initial begin
    rst_i = 1'b1;
    cpl = '0;
    repeat (9) @(posedge core_clk_i);
    @(negedge core_clk_i);
    `CHK("rst_ready", 1'b1, req_ready_o)
    @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_decode();
    t_status();
    t_queue();
    results();
  end

  // about 200 cycles of work expected; twenty times that means a hang
  initial begin
    #100us;
    num_errors++;
    results();
  end
endmodule : testbench
